// *** verilog/ptmr_top.sv ***
// Periodic timer: APB register set, 10-bit counter, comparators and pin logic
//
// Contract
// - Clock select picks divided high, sub or pin edge
// - Run bit enables counting, clear stops it
// - Run rise zeroes counter, fall holds value
// - Run rise restores initial output level
// - Unimplemented control and high bits read zero
// - Mode field: compare, capture, PWM, timer
// - Compare match drives pin: hold, low, high, toggle
// - PWM field: inactive, active, PWM, single pulse
// - Capture trigger: rise, fall, both, disabled
// - Match to initial level shows no change
// - Initial level bit sets pre-match pin level
// - Initial bit sets PWM activity, pulse start
// - Invert bit inverts pin in every mode
// - Capture source: io pin or clock pin
// - Clear select: match A, else P/overflow
// - Overflow clears only with compare P zero
// - Clear select ignored in PWM, pulse, capture
// - Counter read-only, split low and high
// - Compare A held in low/high pair
// - Compare P held in low/high pair
// - Ten-bit up counter with two comparators
// - Pause bit freezes counter, resumes later
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module ptmr_top
  import ptmr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sub_clk_tick,
  input  wire logic        external_clock_pin,
  input  wire logic        timer_io_pin_in,
  output logic             timer_io_pin_out,
  output logic             timer_io_pin_oe,
  output logic             match_a_event,
  output logic             match_p_event,
  output logic             capture_event
);
  ptmr_crc_t        crc;
  ptmr_mpc_t        mpc;
  logic [CNT_W-1:0] counter;
  logic [CNT_W-1:0] compare_a_value;
  logic [CNT_W-1:0] compare_p_value;
  logic [CNT_W-1:0] capture_value;
  logic [1:0]       ck_sync;
  logic [1:0]       io_sync;
  logic             ck_d;
  logic             io_d;
  logic             run_d;
  logic [5:0]       prescale;
  logic             tick;
  logic             out_raw;
  logic             apb_wr;
  logic             apb_rd;
  logic             run_rise;
  logic             match_a;
  logic             match_p;
  logic             overflow;
  logic             clear_cnt;
  logic             pulse_stop;
  logic             trig_edge;
  logic             cap_hit;
  logic             pin_level;
  logic [7:0]       wbyte;

  // High register decode is shared by three register pairs
  function automatic logic [7:0] high_byte(input logic [CNT_W-1:0] v);
    high_byte = {6'h00, v[9:8]};
  endfunction : high_byte

  // APB strobes; slave answers in the access cycle, no wait states
  assign apb_wr = psel && penable && pwrite && pstrb[0];
  assign apb_rd = psel && !penable && !pwrite;
  assign wbyte  = pwdata[7:0];
  assign run_rise = crc.counter_run && !run_d;

  // Pin synchronisers; logic reads the second stage and its one-cycle delayed copy
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ck_sync <= 2'h0;
      io_sync <= 2'h0;
      ck_d    <= 1'b0;
      io_d    <= 1'b0;
      run_d   <= 1'b0;
    end else begin
      ck_sync <= {ck_sync[0], external_clock_pin};
      io_sync <= {io_sync[0], timer_io_pin_in};
      ck_d    <= ck_sync[1];
      io_d    <= io_sync[1];
      run_d   <= crc.counter_run;
    end
  end

  // Prescaler for the high clock divisions; free-running keeps it simple
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prescale <= 6'h00;
    end else begin
      prescale <= prescale + 6'h01;
    end
  end

  // Count enable selection from the clock field
  always_comb begin
    case (crc.counter_clock_select)
      CKS_H_DIV4:   tick = (prescale[1:0] == PRE_MAX[1:0]);
      CKS_H:        tick = 1'b1;
      CKS_H_DIV16:  tick = (prescale[3:0] == PRE_MAX[3:0]);
      CKS_H_DIV64:  tick = (prescale == PRE_MAX);
      CKS_SUB0,
      CKS_SUB1:     tick = sub_clk_tick;
      CKS_EXT_RISE: tick = ck_sync[1] && !ck_d;
      CKS_EXT_FALL: tick = !ck_sync[1] && ck_d;
      default:      tick = 1'b0;
    endcase
  end

  // Comparators against the current count
  assign match_a  = tick && (counter == compare_a_value);
  assign match_p  = tick && (counter == compare_p_value);
  assign overflow = tick && (counter == {CNT_W{1'b1}});

  // Clear condition; clear select only counts in compare and timer modes
  always_comb begin
    if (mpc.operating_mode_select == MODE_PWM && mpc.pin_function_select == PF_3) begin
      clear_cnt = 1'b0; // Single pulse stops at compare A; compare P is unused
    end else if (mpc.operating_mode_select == MODE_PWM ||
                 mpc.operating_mode_select == MODE_CAPTURE) begin
      // A zero compare P would otherwise pin the counter at zero; wrap instead
      clear_cnt = (compare_p_value == '0) ? overflow : match_p;
    end else if (mpc.counter_clear_select) begin
      clear_cnt = match_a;
    end else if (compare_p_value == '0) begin
      clear_cnt = overflow;
    end else begin
      clear_cnt = match_p;
    end
  end

  // Single pulse ends at compare A and clears the run bit
  assign pulse_stop = crc.counter_run && match_a &&
                      mpc.operating_mode_select == MODE_PWM &&
                      mpc.pin_function_select == PF_3;

  // Control register; pulse end beats a software write of the run bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      crc <= CRC_RESET;
    end else begin
      if (apb_wr && paddr == ADDR_CLOCK_RUN_CONTROL) begin
        crc <= wbyte & CRC_WMASK;
      end
      if (pulse_stop) begin
        crc.counter_run <= 1'b0;
      end
    end
  end

  // Mode/pin and compare registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mpc             <= MPC_RESET;
      compare_a_value <= '0;
      compare_p_value <= '0;
    end else if (apb_wr) begin
      case (paddr)
        ADDR_MODE_PIN_CONTROL:  mpc <= wbyte;
        ADDR_COMPARE_A_LOW:     compare_a_value[7:0] <= wbyte;
        ADDR_COMPARE_A_HIGH:    compare_a_value[9:8] <= wbyte[1:0];
        ADDR_COMPARE_P_LOW:     compare_p_value[7:0] <= wbyte;
        ADDR_COMPARE_P_HIGH:    compare_p_value[9:8] <= wbyte[1:0];
        default: ;
      endcase
    end
  end

  // Counter: zeroed on run rise, held when stopped or paused
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      counter <= '0;
    end else if (run_rise) begin
      counter <= '0;
    end else if (crc.counter_run && !crc.counter_pause && tick) begin
      if (pulse_stop) begin
        counter <= counter;
      end else if (clear_cnt) begin
        counter <= '0;
      end else begin
        counter <= counter + 10'h001;
      end
    end
  end

  // Capture trigger edge from the selected pin
  always_comb begin
    logic now;
    logic was;
    now = mpc.capture_source_select ? ck_sync[1] : io_sync[1];
    was = mpc.capture_source_select ? ck_d : io_d;
    case (mpc.pin_function_select)
      PF_0:    trig_edge = now && !was;
      PF_1:    trig_edge = !now && was;
      PF_2:    trig_edge = now ^ was;
      default: trig_edge = 1'b0;
    endcase
  end
  assign cap_hit = trig_edge && crc.counter_run &&
                   mpc.operating_mode_select == MODE_CAPTURE;

  // Capture latch and event pulses
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      capture_value <= '0;
      capture_event <= 1'b0;
      match_a_event <= 1'b0;
      match_p_event <= 1'b0;
    end else begin
      if (cap_hit) begin
        capture_value <= counter;
      end
      capture_event <= cap_hit;
      match_a_event <= match_a && crc.counter_run && !crc.counter_pause;
      match_p_event <= match_p && crc.counter_run && !crc.counter_pause &&
                       !(mpc.counter_clear_select &&
                         mpc.operating_mode_select[0] == mpc.operating_mode_select[1]);
    end
  end

  // Raw output state before polarity
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_raw <= 1'b0;
    end else if (run_rise) begin
      out_raw <= mpc.output_initial_level;
    end else if (crc.counter_run && !crc.counter_pause) begin
      case (mpc.operating_mode_select)
        MODE_COMPARE: begin
          if (match_a) begin
            case (mpc.pin_function_select)
              PF_1:    out_raw <= 1'b0;
              PF_2:    out_raw <= 1'b1;
              PF_3:    out_raw <= !out_raw;
              default: out_raw <= out_raw;
            endcase
          end
        end
        MODE_PWM: begin
          case (mpc.pin_function_select)
            PF_0: out_raw <= !mpc.output_initial_level;
            PF_1: out_raw <= mpc.output_initial_level;
            PF_2: begin
              if (tick) begin
                // Active while next count is below duty, 100% when duty > period
                if (clear_cnt) begin
                  out_raw <= (compare_a_value != '0) ? mpc.output_initial_level
                                                     : !mpc.output_initial_level;
                end else if (counter + 10'h001 == compare_a_value) begin
                  out_raw <= !mpc.output_initial_level;
                end
              end
            end
            default: begin
              if (pulse_stop) begin
                out_raw <= !mpc.output_initial_level;
              end
            end
          endcase
        end
        default: out_raw <= out_raw;
      endcase
    end
  end

  // Pin driver with polarity; pin is input in capture and timer modes
  assign pin_level = out_raw ^ mpc.output_invert;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_io_pin_out <= 1'b0;
      timer_io_pin_oe  <= 1'b0;
    end else begin
      timer_io_pin_out <= pin_level;
      timer_io_pin_oe  <= (mpc.operating_mode_select == MODE_COMPARE) ||
                          (mpc.operating_mode_select == MODE_PWM);
    end
  end

  // APB read data registered in setup cycle, valid in access cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (apb_rd) begin
      case (paddr)
        ADDR_CLOCK_RUN_CONTROL: prdata <= {24'h000000, crc & CRC_WMASK};
        ADDR_MODE_PIN_CONTROL:  prdata <= {24'h000000, mpc};
        ADDR_COUNTER_LOW:       prdata <= {24'h000000, counter[7:0]};
        ADDR_COUNTER_HIGH:      prdata <= {24'h000000, high_byte(counter)};
        ADDR_COMPARE_A_LOW:     prdata <= {24'h000000, compare_a_value[7:0]};
        ADDR_COMPARE_A_HIGH:    prdata <= {24'h000000, high_byte(compare_a_value)};
        ADDR_COMPARE_P_LOW:     prdata <= {24'h000000, compare_p_value[7:0]};
        ADDR_COMPARE_P_HIGH:    prdata <= {24'h000000, high_byte(compare_p_value)};
        default:                prdata <= 32'h00000000;
      endcase
    end
  end

  // Ready always high; unmapped addresses and counter writes flag an error
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      pslverr <= psel && !penable &&
                 (paddr > ADDR_COMPARE_P_HIGH || paddr[1:0] != 2'h0 ||
                  (pwrite && (paddr == ADDR_COUNTER_LOW || paddr == ADDR_COUNTER_HIGH)));
    end
  end

  // Checks
  sequence s_run_rise;
    crc.counter_run && !run_d;
  endsequence

  AST_RUN_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    s_run_rise |=> counter == '0)
    else $error("counter not zero after run rise");
  AST_INIT_LEVEL: assert property (@(posedge core_clk) disable iff (rst)
    s_run_rise |=> out_raw == $past(mpc.output_initial_level))
    else $error("output not at initial level after run rise");
  AST_STOP_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    !crc.counter_run && !run_rise ##1 !crc.counter_run |-> $stable(counter))
    else $error("counter moved while stopped");
  AST_PAUSE_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    crc.counter_pause && !run_rise |=> counter == $past(counter))
    else $error("counter moved while paused");
  AST_HIGH_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    pready && psel && penable && !pwrite && paddr == ADDR_COUNTER_HIGH
      |-> prdata[31:2] == '0)
    else $error("high register upper bits not zero");
  AST_CLR_A: assert property (@(posedge core_clk) disable iff (rst)
    crc.counter_run && !crc.counter_pause && !run_rise && match_a && !pulse_stop &&
      mpc.counter_clear_select && (mpc.operating_mode_select == MODE_COMPARE ||
                                   mpc.operating_mode_select == MODE_TIMER)
      |=> counter == '0)
    else $error("compare A match did not clear counter");
  AST_OVF_P: assert property (@(posedge core_clk) disable iff (rst)
    crc.counter_run && !crc.counter_pause && !run_rise && overflow &&
      compare_p_value != '0 && !clear_cnt |=> counter == '0)
    else $error("overflow wrap without clear");
  AST_TOGGLE: assert property (@(posedge core_clk) disable iff (rst)
    crc.counter_run && !crc.counter_pause && !run_rise && match_a &&
      mpc.operating_mode_select == MODE_COMPARE && mpc.pin_function_select == PF_3
      |=> out_raw != $past(out_raw))
    else $error("toggle missing on compare A match");
  AST_PULSE_END: assert property (@(posedge core_clk) disable iff (rst)
    pulse_stop |=> !crc.counter_run ##1 timer_io_pin_out ==
      (!mpc.output_initial_level ^ mpc.output_invert))
    else $error("single pulse did not end at compare A");
  AST_INVERT: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> timer_io_pin_out == ($past(out_raw) ^ $past(mpc.output_invert)))
    else $error("pin polarity wrong");
  AST_CAPTURE: assert property (@(posedge core_clk) disable iff (rst)
    cap_hit |=> capture_value == $past(counter))
    else $error("capture value not latched");
endmodule : ptmr_top

// *** verilog/ptmr_pkg.sv ***
// Package: register map, field positions and constants of the periodic timer
package ptmr_pkg;
  localparam logic [11:0] ADDR_CLOCK_RUN_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_MODE_PIN_CONTROL  = 12'h004;
  localparam logic [11:0] ADDR_COUNTER_LOW       = 12'h008;
  localparam logic [11:0] ADDR_COUNTER_HIGH      = 12'h00c;
  localparam logic [11:0] ADDR_COMPARE_A_LOW     = 12'h010;
  localparam logic [11:0] ADDR_COMPARE_A_HIGH    = 12'h014;
  localparam logic [11:0] ADDR_COMPARE_P_LOW     = 12'h018;
  localparam logic [11:0] ADDR_COMPARE_P_HIGH    = 12'h01c;
  localparam int CNT_W = 10;
  localparam logic [7:0] CRC_RESET  = 8'h00;
  localparam logic [7:0] CRC_WMASK  = 8'hf8; // Bits 2..0 read as zero
  localparam logic [7:0] MPC_RESET  = 8'h00;
  localparam logic [7:0] HIGH_WMASK = 8'h03; // Bits 7..2 read as zero
  // Clock select codes
  localparam logic [2:0] CKS_H_DIV4  = 3'h0;
  localparam logic [2:0] CKS_H       = 3'h1;
  localparam logic [2:0] CKS_H_DIV16 = 3'h2;
  localparam logic [2:0] CKS_H_DIV64 = 3'h3;
  localparam logic [2:0] CKS_SUB0    = 3'h4;
  localparam logic [2:0] CKS_SUB1    = 3'h5;
  localparam logic [2:0] CKS_EXT_RISE = 3'h6;
  localparam logic [2:0] CKS_EXT_FALL = 3'h7;
  localparam logic [5:0] PRE_MAX     = 6'h3f;
  // Mode codes
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_TIMER   = 2'h3;
  // Pin function codes
  localparam logic [1:0] PF_0 = 2'h0;
  localparam logic [1:0] PF_1 = 2'h1;
  localparam logic [1:0] PF_2 = 2'h2;
  localparam logic [1:0] PF_3 = 2'h3;

  typedef struct packed {
    logic       counter_pause;
    logic [2:0] counter_clock_select;
    logic       counter_run;
    logic [2:0] unused;
  } ptmr_crc_t;

  typedef struct packed {
    logic [1:0] operating_mode_select;
    logic [1:0] pin_function_select;
    logic       output_initial_level;
    logic       output_invert;
    logic       capture_source_select;
    logic       counter_clear_select;
  } ptmr_mpc_t;
endpackage : ptmr_pkg

// *** dv/ptmr_pins_model.sv ***
// Far-side pin model: clock and capture pin drivers, shared timer pin level
`timescale 1ns/1ns
module ptmr_pins_model (
  input  wire logic core_clk,
  input  wire logic timer_io_pin_out,
  input  wire logic timer_io_pin_oe,
  output logic      external_clock_pin,
  output logic      timer_io_pin_in
);
  logic io_drive;

  // Wire level: the timer wins while it drives, otherwise this model's level
  assign timer_io_pin_in = timer_io_pin_oe ? timer_io_pin_out : io_drive;

  initial begin
    external_clock_pin = 1'b0;
    io_drive           = 1'b0;
  end

  // Full pulses, 8 cycles per level so the 2-FF synchroniser sees every edge
  task automatic pulse(input logic on_clk_pin, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge core_clk);
      if (on_clk_pin) begin
        external_clock_pin <= ~external_clock_pin;
      end else begin
        io_drive <= ~io_drive;
      end
      repeat (7) @(posedge core_clk);
    end
  endtask : pulse
endmodule : ptmr_pins_model

// *** dv/tb_ptmr_top.sv ***
// Self-checking bench for the periodic timer register block
`timescale 1ns/1ns
module tb_ptmr_top;
  import ptmr_pkg::*;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        sub_clk_tick, external_clock_pin, timer_io_pin_in;
  logic        timer_io_pin_out, timer_io_pin_oe, capture_event;
  logic        match_a_event, match_p_event;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [9:0]  cnt;
  int          fails, tests_run, cap_cnt, sub_div, a_cnt, p_cnt;

  ptmr_top i_ptmr_top (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sub_clk_tick(sub_clk_tick),
    .external_clock_pin(external_clock_pin), .timer_io_pin_in(timer_io_pin_in),
    .timer_io_pin_out(timer_io_pin_out), .timer_io_pin_oe(timer_io_pin_oe),
    .match_a_event(match_a_event), .match_p_event(match_p_event),
    .capture_event(capture_event));

  ptmr_pins_model i_ptmr_pins_model (.core_clk(core_clk), .timer_io_pin_out(timer_io_pin_out),
    .timer_io_pin_oe(timer_io_pin_oe), .external_clock_pin(external_clock_pin),
    .timer_io_pin_in(timer_io_pin_in));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Sub clock enable every 16 cycles; capture pulses counted as they come
  always @(posedge core_clk) begin
    sub_div      <= (sub_div + 1) % 16;
    sub_clk_tick <= (sub_div == 15);
    if (capture_event === 1'b1) begin
      cap_cnt <= cap_cnt + 1;
    end
    if (match_a_event === 1'b1) begin
      a_cnt <= a_cnt + 1;
    end
    if (match_p_event === 1'b1) begin
      p_cnt <= p_cnt + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (int i = 0; i <= 20; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
      if (i == 20) begin
        fails++;
        summarize();
      end
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0);
    check(rd, exp, msg);
  endtask : rchk

  task automatic run_ctl(input logic pause, input logic [2:0] cks, input logic on);
    apb(1'b1, ADDR_CLOCK_RUN_CONTROL, {24'h0, pause, cks, on, 3'h0});
  endtask : run_ctl

  // Mode and compare values are only touched with the timer stopped
  task automatic setup(input logic [1:0] mode, pf, input logic init, inv, caps, clr,
                       input logic [9:0] a, p);
    run_ctl(1'b0, CKS_H, 1'b0);
    apb(1'b1, ADDR_MODE_PIN_CONTROL, {24'h0, mode, pf, init, inv, caps, clr});
    apb(1'b1, ADDR_COMPARE_A_LOW, {24'h0, a[7:0]});
    apb(1'b1, ADDR_COMPARE_A_HIGH, {30'h0, a[9:8]});
    apb(1'b1, ADDR_COMPARE_P_LOW, {24'h0, p[7:0]});
    apb(1'b1, ADDR_COMPARE_P_HIGH, {30'h0, p[9:8]});
  endtask : setup

  task automatic rd_cnt();
    apb(1'b0, ADDR_COUNTER_LOW, 32'h0);
    cnt[7:0] = rd[7:0];
    apb(1'b0, ADDR_COUNTER_HIGH, 32'h0);
    cnt[9:8] = rd[1:0];
  endtask : rd_cnt

  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      rchk(12'(4 * i), 32'h0, "reset value");
    end
    apb(1'b1, ADDR_CLOCK_RUN_CONTROL, 32'hff);
    rchk(ADDR_CLOCK_RUN_CONTROL, 32'hf8, "control low bits");
    run_ctl(1'b0, CKS_H, 1'b0);
    apb(1'b1, ADDR_COMPARE_A_LOW, 32'ha5);
    apb(1'b1, ADDR_COMPARE_A_HIGH, 32'hff);
    apb(1'b1, ADDR_COMPARE_P_HIGH, 32'hfe);
    pstrb <= 4'h0;
    apb(1'b1, ADDR_COMPARE_A_LOW, 32'h11);
    pstrb <= 4'hf;
    rchk(ADDR_COMPARE_A_LOW, 32'ha5, "strobe off write");
    rchk(ADDR_COMPARE_A_HIGH, 32'h03, "compare a high");
    rchk(ADDR_COMPARE_P_HIGH, 32'h02, "compare p high");
    apb(1'b1, ADDR_COUNTER_LOW, 32'h55);
    check(err, 32'h1, "counter write refused");
    rchk(ADDR_COUNTER_LOW, 32'h0, "counter untouched");
    apb(1'b1, 12'h020, 32'h0);
    check(err, 32'h1, "unmapped address");
  endtask : t_regs

  // Pin-edge clocking, hold on stop, zero on start, pause and resume
  task automatic t_ext();
    logic [2:0] cks;
    for (int k = 0; k < 2; k++) begin
      cks = k ? CKS_EXT_FALL : CKS_EXT_RISE;
      setup(MODE_TIMER, PF_0, 1'b0, 1'b0, 1'b0, 1'b0, 10'h0, 10'h0);
      run_ctl(1'b0, cks, 1'b1);
      i_ptmr_pins_model.pulse(1'b1, 5);
      run_ctl(1'b0, cks, 1'b0);
      rd_cnt();
      check(cnt, 32'd5, "pin edge count");
      repeat (20) @(posedge core_clk);
      rd_cnt();
      check(cnt, 32'd5, "held while off");
      run_ctl(1'b1, cks, 1'b1);
      rd_cnt();
      check(cnt, 32'd0, "zero on start");
      i_ptmr_pins_model.pulse(1'b1, 2);
      rd_cnt();
      check(cnt, 32'd0, "frozen by pause");
      run_ctl(1'b0, cks, 1'b1);
      i_ptmr_pins_model.pulse(1'b1, 3);
      rd_cnt();
      check(cnt, 32'd3, "resumed count");
    end
  endtask : t_ext

  // Internal clock rates over a 640-cycle run; compare P zero lets it run on
  task automatic t_div();
    logic [2:0] codes [6] = '{CKS_H_DIV4, CKS_H, CKS_H_DIV16, CKS_H_DIV64, CKS_SUB0, CKS_SUB1};
    int         exp [6]   = '{160, 640, 40, 10, 40, 40};
    for (int k = 0; k < 6; k++) begin
      setup(MODE_TIMER, PF_0, 1'b0, 1'b0, 1'b0, 1'b0, 10'h0, 10'h0);
      run_ctl(1'b0, codes[k], 1'b1);
      repeat (637) @(posedge core_clk);
      run_ctl(1'b0, codes[k], 1'b0);
      rd_cnt();
      check(32'(cnt > exp[k] - 4 && cnt < exp[k] + 4), 32'h1, "clock rate");
    end
  endtask : t_div

  // Highest counter value seen while running at the core rate
  task automatic sweep(input logic [1:0] mode, input logic clr, input logic [9:0] a, p);
    logic [9:0] top;
    int         base;
    top = 10'h0;
    setup(mode, PF_2, 1'b0, 1'b0, 1'b0, clr, a, p);
    run_ctl(1'b0, CKS_H, 1'b1);
    base = p_cnt;
    for (int i = 0; i < 25; i++) begin
      rd_cnt();
      if (cnt > top) top = cnt;
    end
    check(32'(top >= 10'd32 && top <= 10'd40), 32'h1, "counter span");
    // Clear on A silences the P event in compare and timer modes
    check(32'(p_cnt != base), 32'(!(clr && mode == MODE_TIMER)), "p events");
  endtask : sweep

  task automatic t_cmp();
    logic [1:0] pf [5]    = '{PF_0, PF_1, PF_2, PF_3, PF_2};
    logic       init [5]  = '{1, 1, 0, 0, 1};
    logic       inv [5]   = '{0, 0, 0, 1, 1};
    logic       after [5] = '{1, 0, 1, 1, 1};
    int         base;
    for (int k = 0; k < 5; k++) begin
      setup(MODE_COMPARE, pf[k], init[k], inv[k], 1'b0, 1'b0, 10'd20, 10'h0);
      run_ctl(1'b0, CKS_H, 1'b1);
      repeat (3) @(posedge core_clk);
      base = a_cnt;
      check(timer_io_pin_out, init[k] ^ inv[k], "initial level");
      check(timer_io_pin_oe, 32'h1, "pin driven");
      repeat (40) @(posedge core_clk);
      check(timer_io_pin_out, after[k] ^ inv[k], "level after match");
      check(a_cnt - base, 32'h1, "one compare a event");
    end
  endtask : t_cmp

  task automatic t_pwm();
    int hi;
    int d;
    for (int k = 0; k < 2; k++) begin
      setup(MODE_PWM, 2'(k), 1'b1, 1'b0, 1'b0, 1'b0, 10'd4, 10'd10);
      run_ctl(1'b0, CKS_H, 1'b1);
      repeat (20) @(posedge core_clk);
      check(timer_io_pin_out, 32'(k), "forced level");
    end
    for (int k = 0; k < 3; k++) begin
      setup(MODE_PWM, PF_2, 1'(k != 1), 1'(k == 2), 1'b0, 1'b0, 10'd4, 10'd10);
      run_ctl(1'b0, CKS_H, 1'b1);
      hi = 0;
      d  = (k == 0) ? 40 : 60;
      repeat (100) begin
        @(posedge core_clk);
        if (timer_io_pin_out === 1'b1) hi++;
      end
      check(32'(hi > d - 6 && hi < d + 6), 32'h1, "pwm duty");
    end
    setup(MODE_PWM, PF_3, 1'b1, 1'b0, 1'b0, 1'b0, 10'd8, 10'h0);
    run_ctl(1'b0, CKS_H, 1'b1);
    repeat (3) @(posedge core_clk);
    check(timer_io_pin_out, 32'h1, "pulse leading");
    repeat (20) @(posedge core_clk);
    check(timer_io_pin_out, 32'h0, "pulse trailing");
    rchk(ADDR_CLOCK_RUN_CONTROL, {24'h0, 1'b0, CKS_H, 1'b0, 3'h0}, "run cleared");
  endtask : t_pwm

  task automatic t_cap();
    int base;
    int exp [4] = '{1, 1, 2, 0};
    for (int k = 0; k < 8; k++) begin
      setup(MODE_CAPTURE, 2'(k % 4), 1'b0, 1'b0, 1'(k / 4), 1'b0, 10'h0, 10'h0);
      run_ctl(1'b0, CKS_H, 1'b1);
      base = cap_cnt;
      i_ptmr_pins_model.pulse(1'(k / 4), 1);
      check(cap_cnt - base, exp[k % 4], "capture edges");
      base = cap_cnt;
      i_ptmr_pins_model.pulse(1'(1 - k / 4), 1);
      check(cap_cnt - base, 32'h0, "other pin ignored");
    end
  endtask : t_cap

  initial begin
    rst          = 1'b1;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0;
    pstrb        = 4'hf;
    sub_clk_tick = 1'b0;
    sub_div      = 0;
    cap_cnt      = 0;
    a_cnt        = 0;
    p_cnt        = 0;
    fails        = 0;
    tests_run    = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_ext();
    t_div();
    sweep(MODE_TIMER, 1'b0, 10'h3ff, 10'd40);
    sweep(MODE_TIMER, 1'b1, 10'd40, 10'd10);
    sweep(MODE_PWM, 1'b1, 10'd10, 10'd40);
    t_cmp();
    t_pwm();
    t_cap();
    summarize();
  end
endmodule : tb_ptmr_top
